/* verilog/vector_map_pkg.sv */
/*
  constants for the reset entry and vector table address map.
  assumes word addresses of 24 bits into program memory.
*/
`default_nettype none
package vector_map_pkg;
  localparam int addr_width = 24;
  localparam int vector_count = 118;
  localparam int trap_count = 8;
  localparam logic [addr_width-1:0] reset_address = 24'h000000;
  localparam logic [addr_width-1:0] primary_table_base = 24'h000004;
  localparam logic [addr_width-1:0] primary_vector0 = 24'h000014;
  localparam logic [addr_width-1:0] alternate_table_base = 24'h000104;
  localparam logic [addr_width-1:0] alternate_vector0 = 24'h000114;
  localparam logic [addr_width-1:0] code_start = 24'h000200;
  localparam logic [addr_width-1:0] slot_step = 24'h000002;
  typedef enum logic [1:0] {
    idle_state,
    fetch_state,
    done_state
  } fetch_state_type;
endpackage
`default_nettype wire

/* verilog/vector_slot_address.sv */
/*
  combinational slot address for a trap or interrupt vector.
  assumes the caller holds the number in range.
*/
`timescale 1ns/10ps
`default_nettype none
module vector_slot_address
  import vector_map_pkg::*;
(
  input wire logic use_alternate,
  input wire logic is_trap,
  input wire logic [6:0] number,
  output logic [addr_width-1:0] address
);
  logic [addr_width-1:0] base;
  logic [addr_width-1:0] offset;
  always_comb
  begin
    // same slot layout in both tables, only the base moves
    if (is_trap)
      base = use_alternate ? alternate_table_base : primary_table_base;
    else
      base = use_alternate ? alternate_vector0 : primary_vector0;
    offset = addr_width'(number) * slot_step; // see RULE10
    address = base + offset;
  end
endmodule // vector_slot_address
`default_nettype wire

/* verilog/reset_vector_map.sv */
/*
  reset entry and vector fetch address generator for the core.
  assumes a core that requests a vector and then reads the 24-bit
  handler address from program memory, returned with a valid strobe.
*/
`timescale 1ns/10ps
`default_nettype none
// How it works
// RULE1 - reset bypasses vector logic: no arbitration, no table fetch.
// RULE2 - any reset clears registers, forcing program counter to zero.
// RULE3 - after reset fetching starts at word address zero.
// RULE4 - loader should fill unused slots with a software-reset handler.
// RULE5 - primary table: vector 0 at 0x14, 52 at 0x7c, 117 at 0xfe.
// RULE6 - alternate table: vector 0 at 0x114, 52 at 0x17c, 117 at 0x1fe.
// RULE7 - primary table starts at 0x4; each slot holds 24-bit address.
// RULE8 - select bit set takes every vector from the alternate table.
// RULE9 - lower slot address means higher natural priority.
// RULE10 - vector n sits at vector-0 address plus 2n, n up to 117.
module reset_vector_map
  import vector_map_pkg::*;
#(
  parameter int vectors = vector_count
)
(
  input wire logic clk,
  input wire logic rst,
  input wire logic alternate_table_select,
  input wire logic [vectors-1:0] irq_pending,
  input wire logic [trap_count-1:0] trap_pending,
  input wire logic take_request,
  input wire logic [addr_width-1:0] mem_data,
  input wire logic mem_valid,
  output logic [addr_width-1:0] fetch_address,
  output logic fetch_strobe,
  output logic [addr_width-1:0] program_counter,
  output logic pc_load,
  output logic [6:0] taken_number,
  output logic taken_trap,
  output logic busy
);
  fetch_state_type state;
  logic [addr_width-1:0] slot_addr;
  logic [vectors:0] irq_below;
  logic [6:0] irq_code [vectors+1];
  logic [trap_count:0] trap_below;
  logic [6:0] trap_code [trap_count+1];
  logic [6:0] win_number;
  logic win_trap;
  logic win_any;
  logic accept;
  logic answer;
  logic [6:0] held_number;
  logic held_trap;

  // ----------------------------------------
  // natural priority
  // ----------------------------------------
  // a ripple from slot 0 upward: an entry wins only when nothing
  // below it is pending, so the lowest address wins; see RULE9
  // a long ripple but small, and a 100 ns cycle leaves room for it
  assign irq_below[0] = 1'b0;
  assign irq_code[0] = 7'h00;
  for (genvar g = 0; g < vectors; g++)
  begin : irq_scan
    assign irq_below[g+1] = irq_below[g] | irq_pending[g];
    assign irq_code[g+1] = irq_code[g] |
      ((irq_pending[g] && !irq_below[g]) ? 7'(g) : 7'h00);
  end

  assign trap_below[0] = 1'b0;
  assign trap_code[0] = 7'h00;
  for (genvar t = 0; t < trap_count; t++)
  begin : trap_scan
    assign trap_below[t+1] = trap_below[t] | trap_pending[t];
    assign trap_code[t+1] = trap_code[t] |
      ((trap_pending[t] && !trap_below[t]) ? 7'(t) : 7'h00);
  end

  // traps sit below interrupt vector 0, so any trap outranks them all
  assign win_trap = trap_below[trap_count];
  assign win_any = win_trap | irq_below[vectors];
  assign win_number = win_trap ? trap_code[trap_count] : irq_code[vectors];

  // ----------------------------------------
  // request acceptance
  // ----------------------------------------
  // a take while busy is simply not seen; the core must wait
  assign accept = state == idle_state && take_request && win_any;
  // a valid outside the done state belongs to no fetch and is dropped
  assign answer = state == done_state && mem_valid;

  // ----------------------------------------
  // slot address
  // ----------------------------------------
  // table and slot chosen together; see RULE5 RULE6 RULE7 RULE8 RULE10
  vector_slot_address vector_slot_address_inst (
    .use_alternate(alternate_table_select),
    .is_trap(held_trap),
    .number(held_number),
    .address(slot_addr)
  );

  // ----------------------------------------
  // vector fetch sequence
  // ----------------------------------------
  // reset never enters this sequence, it only clears it; see RULE1
  always_ff @(posedge clk)
  begin
    if (rst)
    begin
      state <= idle_state;
    end
    else
    begin
      unique case (state)
        idle_state:
        begin
          if (accept)
            state <= fetch_state;
        end
        fetch_state:
        begin
          state <= done_state;
        end
        done_state:
        begin
          if (answer)
            state <= idle_state;
        end
      endcase
    end
  end

  // ----------------------------------------
  // request held for the fetch
  // ----------------------------------------
  always_ff @(posedge clk)
  begin
    if (rst)
    begin
      held_number <= 7'h00;
      held_trap <= 1'b0;
    end
    else if (accept)
    begin
      held_number <= win_number;
      held_trap <= win_trap;
    end
  end

  // ----------------------------------------
  // busy flag
  // ----------------------------------------
  // busy spans the whole fetch so a second take cannot overlap it
  always_ff @(posedge clk)
  begin
    if (rst)
    begin
      busy <= 1'b0;
    end
    else if (accept)
    begin
      busy <= 1'b1;
    end
    else if (answer)
    begin
      busy <= 1'b0;
    end
  end

  // ----------------------------------------
  // fetch strobe and address
  // ----------------------------------------
  // the address stays after the strobe so the core may latch it late
  always_ff @(posedge clk)
  begin
    if (rst)
    begin
      fetch_strobe <= 1'b0;
      fetch_address <= reset_address; // see RULE3
    end
    else
    begin
      fetch_strobe <= state == fetch_state;
      if (state == fetch_state)
        fetch_address <= slot_addr;
    end
  end

  // ----------------------------------------
  // program counter
  // ----------------------------------------
  always_ff @(posedge clk)
  begin
    if (rst)
    begin
      program_counter <= reset_address; // see RULE2 RULE3
      pc_load <= 1'b0;
    end
    else
    begin
      pc_load <= answer;
      // the slot content is a 24-bit handler address; see RULE7
      if (answer)
        program_counter <= mem_data;
    end
  end

  // ----------------------------------------
  // vector taken
  // ----------------------------------------
  always_ff @(posedge clk)
  begin
    if (rst)
    begin
      taken_number <= 7'h00;
      taken_trap <= 1'b0;
    end
    else if (answer)
    begin
      taken_number <= held_number;
      taken_trap <= held_trap;
    end
  end

endmodule // reset_vector_map
`default_nettype wire

/* bench/map_properties.sv */
/* checks on the vector map ports; assumes one clock, sync reset */
`timescale 1ns/10ps
`default_nettype none
module map_properties
(
  input wire logic clk,
  input wire logic rst,
  input wire logic alternate_table_select,
  input wire logic mem_valid,
  input wire logic [23:0] fetch_address,
  input wire logic fetch_strobe,
  input wire logic [23:0] program_counter,
  input wire logic pc_load,
  input wire logic busy
);
  default clocking @(posedge clk);
  endclocking
  default disable iff (rst);
  sequence answered; busy && mem_valid; endsequence
  sequence taken; $rose(busy); endsequence
  chk_take_fetch: assert property (taken |=> fetch_strobe)
    else $error("late fetch");
  chk_reset_clear: assert property (disable iff (1'b0)
    rst |=> program_counter == 24'h0 && !busy) else $error("no clear");
  chk_reset_bypass: assert property (disable iff (1'b0)
    rst |=> !fetch_strobe && !pc_load) else $error("reset fetch");
  chk_start_zero: assert property ($fell(rst) |->
    program_counter == 24'h0 && fetch_address == 24'h0) else $error("start");
  chk_fetch_busy: assert property (fetch_strobe |-> busy)
    else $error("stray fetch");
  chk_load_answer: assert property (answered |=> pc_load && !busy)
    else $error("no load");
  chk_primary_span: assert property (
    fetch_strobe && !alternate_table_select |->
    fetch_address inside {[24'h4:24'hfe]}) else $error("primary");
  chk_alt_span: assert property (
    fetch_strobe && alternate_table_select |->
    fetch_address inside {[24'h104:24'h1fe]}) else $error("alternate");
  chk_even_slot: assert property (fetch_strobe |-> !fetch_address[0])
    else $error("odd slot");
endmodule // map_properties
bind reset_vector_map map_properties map_properties_inst (.*);
`default_nettype wire

/* bench/core_model.sv */
/* core model: answers a strobe with a handler word; same clk as map */
`timescale 1ns/10ps
`default_nettype none
module core_model
(
  input wire logic clk,
  input wire logic fetch_strobe,
  input wire logic [23:0] fetch_address,
  input wire logic slow,
  output logic mem_valid,
  output logic [23:0] mem_data
);
  logic [23:0] a = 24'h0;
  logic [1:0] n = 2'h0;
  initial mem_data = 24'h0;
  always @(posedge clk)
  begin
    mem_valid <= n == 2'h1;
    // idle data toggles so a stale word never passes
    mem_data <= n == 2'h1 ? a ^ 24'ha50000 : ~mem_data;
    a <= fetch_strobe ? fetch_address : a;
    n <= fetch_strobe ? {slow, 1'b1} : n - 2'(n != 2'h0);
  end
endmodule // core_model
`default_nettype wire

/* bench/reset_vector_map_bench.sv */
/* bench for the vector map; core_model answers every fetch */
`timescale 1ns/10ps
`default_nettype none
module reset_vector_map_bench;
  logic clk = 0, rst = 1, take_request = 0, alternate_table_select = 0;
  logic mem_valid, fetch_strobe, pc_load, taken_trap, busy, slow = 0;
  logic [117:0] irq_pending = '0;
  logic [7:0] trap_pending = '0;
  logic [23:0] mem_data, fetch_address, program_counter, a;
  logic [6:0] taken_number;
  int n_checks = 0, n_mismatch = 0, i, k, v;
  reset_vector_map reset_vector_map_inst (.*);
  core_model core_model_inst (.*);
  always #50 clk = ~clk;
  task chk(input logic [23:0] g, e);
    n_checks++;
    if (g !== e)
    begin
      n_mismatch++;
      $display("ERROR %0t got %h want %h", $time, g, e);
    end
  endtask
  // traps fill the slots below vector 0, so index v into the joined
  // list of traps and vectors sits at table base plus 2v
  function automatic logic [23:0] slot_of(input int v, input logic alt);
    return (alt ? 24'h104 : 24'h4) + 24'(2 * v);
  endfunction
  function automatic logic [23:0] code_of(input int v);
    return 24'(v < 8 ? 128 + v : v - 8);
  endfunction
  task end_of_test;
    $display("checks %0d mismatches %0d", n_checks, n_mismatch);
    if (n_mismatch == 0 && n_checks > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask
  initial
  begin
    void'($urandom(32'h5d5b5b9d));
    repeat (12) @(posedge clk);
    rst <= 1'b0;
    @(negedge clk);
    chk(program_counter | fetch_address, 24'h0);
    chk(24'({busy, fetch_strobe, pc_load}), 24'h0);
    for (i = 0; i < 48; i++)
    begin
      // corners first: vectors 0, 52, 117 both tables, then each trap
      v = i < 2 ? 8 : i < 4 ? 60 : i < 6 ? 125 : i < 14 ? i - 6 :
        $urandom % 126;
      @(posedge clk);
      {irq_pending, trap_pending} <= 126'({4{$urandom}} << v) | 126'h1 << v;
      alternate_table_select <= i[0];
      slow <= 1'($urandom);
      take_request <= 1'b1;
      a = slot_of(v, i[0]);
      for (k = 0; k < 6 && fetch_strobe !== 1'b1; k++) @(negedge clk);
      chk(24'({fetch_strobe, busy}), 24'h3);
      chk(fetch_address, a);
      @(posedge clk) take_request <= 1'b0;
      for (k = 0; k < 9 && pc_load !== 1'b1; k++) @(negedge clk);
      chk(24'({pc_load, busy}), 24'h2);
      chk(program_counter, a ^ 24'ha50000);
      chk(24'({taken_trap, taken_number}), code_of(v));
    end
    // reset in mid-fetch: the fetch is dropped, its late answer ignored
    @(posedge clk) take_request <= 1'b1;
    for (k = 0; k < 6 && fetch_strobe !== 1'b1; k++) @(negedge clk);
    chk(24'({fetch_strobe, busy}), 24'h3);
    @(posedge clk) rst <= 1'b1;
    take_request <= 1'b0;
    @(posedge clk) rst <= 1'b0;
    @(negedge clk);
    chk(program_counter | fetch_address, 24'h0);
    chk(24'({busy, fetch_strobe, pc_load}), 24'h0);
    repeat (4) @(negedge clk) chk(24'({busy, pc_load}), 24'h0);
    end_of_test;
  end
  initial
  begin
    #200000;
    n_mismatch++;
    end_of_test;
  end
endmodule // reset_vector_map_bench
`default_nettype wire
